//--- hw/mlfr_dev.sv
// Flash end: decodes the four-lane and two-lane read commands and returns data.
// Assumes the link clock and chip select come from the host and are sampled here.
module mlfr_dev
    import mlfr_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int MEM_BYTES = 256
) (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Sync reset, active high
    mlfr_link_if.dev link, // Flash link
    input wire logic [7:0] first_config_register, // Lane enable and latency code
    input wire logic wide_address_select, // Four-byte address for base opcodes
    output logic continuous_mode, // Two-lane continuous mode held
    output logic busy // Chip select active
);
    // ------------------------------------------------------------
    // Synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] sck_s, cs_s;
    logic [3:0] io_s1, io_s2;
    always_ff @(posedge ref_clk) begin
        sck_s <= {sck_s[1:0], link.sck};
        cs_s <= {cs_s[1:0], link.cs_n};
        io_s1 <= link.io;
        io_s2 <= io_s1;
    end
    wire sck_rise = sck_s[1] & ~sck_s[2];
    wire sck_fall = ~sck_s[1] & sck_s[2];
    wire cs_low = ~cs_s[1];
    wire cs_rise = cs_s[1] & ~cs_s[2];
    wire cs_fall = ~cs_s[1] & cs_s[2];

    // Array content; a pattern stands in for programmed data
    logic [7:0] mem [MEM_BYTES];
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= 8'(i * 7 + 3);
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    mlfr_state_type state;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [5:0] bit_cnt;
    logic [5:0] addr_len;
    logic [3:0] cyc_cnt;
    logic [3:0] dummy_len;
    logic [7:0] mode_bits;
    logic two_lane;
    logic [7:0] data_sr;
    logic [2:0] nib_cnt;
    logic [3:0] edge_cnt;
    logic cont_keep;
    logic first_fall;
    logic [3:0] out_q;
    logic [3:0] oe_n_q;

    // Dummy count from latency code
    always_comb begin
        case (first_config_register[7:6])
            LC_DUMMY_0: dummy_len = DUMMY_LC0;
            LC_DUMMY_1: dummy_len = DUMMY_LC1;
            LC_DUMMY_2: dummy_len = DUMMY_LC2;
            default: dummy_len = DUMMY_LC3;
        endcase
    end
    wire [7:0] next_opcode = {opcode[6:0], io_s2[0]};
    wire [ADDR_W-1:0] rd_addr = addr[ADDR_W-1:0];
    wire [7:0] rd_byte = mem[rd_addr % MEM_BYTES];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= MLFR_IDLE;
            opcode <= 8'h00;
            addr <= 32'h0;
            bit_cnt <= 6'h0;
            addr_len <= ADDR_BITS_NARROW;
            cyc_cnt <= 4'h0;
            mode_bits <= 8'h00;
            two_lane <= 1'b0;
            data_sr <= 8'h00;
            nib_cnt <= 3'h0;
            edge_cnt <= 4'h0;
            cont_keep <= 1'b0;
            continuous_mode <= 1'b0;
            first_fall <= 1'b0;
            out_q <= 4'h0;
            oe_n_q <= 4'hF;
            busy <= 1'b0;
        end else begin
            busy <= cs_low;
            if (cs_rise) begin
                // Chip select high ends any command
                state <= MLFR_IDLE;
                oe_n_q <= 4'hF;
                // Short pulse without valid sequence drops mode
                if (edge_cnt <= SHORT_PULSE_EDGES && state != MLFR_DATA
                        && state != MLFR_DUMMY && state != MLFR_MODE) begin
                    continuous_mode <= 1'b0;
                end else begin
                    continuous_mode <= cont_keep;
                end
            end else if (cs_fall) begin
                edge_cnt <= 4'h0;
                bit_cnt <= 6'h0;
                addr <= 32'h0;
                if (continuous_mode) begin
                    // No opcode in continuous mode
                    state <= MLFR_ADDR;
                    two_lane <= 1'b1;
                end else begin
                    state <= MLFR_OPCODE;
                    two_lane <= 1'b0;
                    cont_keep <= 1'b0; // Old mode byte must not survive a new opcode
                end
            end else if (cs_low) begin
                if (sck_rise && edge_cnt != 4'hF) begin
                    edge_cnt <= edge_cnt + 4'h1;
                end
                case (state)
                    MLFR_OPCODE: if (sck_rise) begin
                        // Opcode one bit per rising edge
                        opcode <= next_opcode;
                        bit_cnt <= bit_cnt + 6'h1;
                        if (bit_cnt == 6'(OPCODE_BITS - 4'h1)) begin
                            bit_cnt <= 6'h0;
                            addr_len <= (next_opcode == OP_FOUR_LANE_WIDE
                                || next_opcode == OP_TWO_LANE_WIDE
                                || wide_address_select) ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
                            two_lane <= next_opcode == OP_TWO_LANE
                                || next_opcode == OP_TWO_LANE_WIDE;
                            // Four-lane read needs lane enable
                            if (next_opcode == OP_TWO_LANE || next_opcode == OP_TWO_LANE_WIDE
                                    || ((next_opcode == OP_FOUR_LANE
                                    || next_opcode == OP_FOUR_LANE_WIDE)
                                    && first_config_register[QUAD_ENABLE_BIT])) begin
                                state <= MLFR_ADDR;
                            end else begin
                                state <= MLFR_IGNORE;
                            end
                        end
                    end
                    MLFR_ADDR: if (sck_rise) begin
                        if (two_lane) begin
                            // Two address bits per edge
                            addr <= {addr[29:0], io_s2[1:0]};
                            bit_cnt <= bit_cnt + 6'h2;
                            if (bit_cnt + 6'h2 == addr_len) begin
                                state <= MLFR_MODE;
                                cyc_cnt <= 4'h0;
                            end
                        end else begin
                            addr <= {addr[30:0], io_s2[0]};
                            bit_cnt <= bit_cnt + 6'h1;
                            if (bit_cnt + 6'h1 == addr_len) begin
                                state <= MLFR_DUMMY;
                                cyc_cnt <= 4'h0;
                                first_fall <= 1'b1;
                            end
                        end
                    end
                    MLFR_MODE: if (sck_rise) begin
                        // Four mode cycles, two bits each
                        mode_bits <= {mode_bits[5:0], io_s2[1:0]};
                        cyc_cnt <= cyc_cnt + 4'h1;
                        if (cyc_cnt == 4'h1) begin
                            // Upper nibble complete; lower ignored
                            cont_keep <= {mode_bits[1:0], io_s2[1:0]} == MODE_CONT;
                        end
                        if (cyc_cnt == MODE_CYCLES - 4'h1) begin
                            state <= MLFR_DUMMY;
                            cyc_cnt <= 4'h0;
                            first_fall <= 1'b1;
                        end
                    end
                    MLFR_DUMMY: if (sck_fall) begin
                        // Lines ignored; count falling to falling
                        if (first_fall && dummy_len != 4'h0) begin
                            first_fall <= 1'b0;
                        end else if (cyc_cnt + 4'h1 >= dummy_len || dummy_len == 4'h0) begin
                            state <= MLFR_DATA;
                            data_sr <= rd_byte;
                            nib_cnt <= 3'h0;
                            oe_n_q <= two_lane ? 4'hC : 4'h0;
                            // MSB first, high lane carries MSB
                            out_q <= two_lane ? {2'b00, rd_byte[7:6]} : rd_byte[7:4];
                            addr <= addr + 32'h1;
                        end else begin
                            cyc_cnt <= cyc_cnt + 4'h1;
                        end
                    end
                    MLFR_DATA: if (sck_fall) begin
                        if (two_lane) begin
                            // Two bits per falling edge
                            if (nib_cnt == 3'h3) begin
                                data_sr <= rd_byte;
                                out_q <= {2'b00, rd_byte[7:6]};
                                addr <= addr + 32'h1; // Wrap at top
                                nib_cnt <= 3'h0;
                            end else begin
                                out_q <= {2'b00, data_sr[5 - 2 * nib_cnt -: 2]};
                                nib_cnt <= nib_cnt + 3'h1;
                            end
                        end else begin
                            // Nibble per falling edge
                            if (nib_cnt == 3'h1) begin
                                data_sr <= rd_byte;
                                out_q <= rd_byte[7:4];
                                addr <= addr + 32'h1;
                                nib_cnt <= 3'h0;
                            end else begin
                                out_q <= data_sr[3:0];
                                nib_cnt <= nib_cnt + 3'h1;
                            end
                        end
                    end
                    MLFR_IGNORE: begin
                        oe_n_q <= 4'hF;
                    end
                    default: state <= MLFR_IDLE;
                endcase
            end
        end
    end

    // Address wraps since only low bits index the array
    assign link.dev_out = out_q;
    assign link.dev_oe_n = oe_n_q;
endmodule

//--- hw/mlfr_host.sv
// Host controller: issues one read per start pulse and collects data bytes.
// Assumes the flash end samples chip select, clock and lines with ref_clk.
module mlfr_host
    import mlfr_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic reset, // Sync reset, active high
    mlfr_link_if.host link, // Flash link
    input wire logic start, // One-cycle request pulse
    input wire logic [7:0] opcode, // Read opcode, zero means continuous
    input wire logic [31:0] address, // Start address
    input wire logic wide, // Send four address bytes
    input wire logic [7:0] mode, // Mode byte for two-lane read
    input wire logic [3:0] dummy, // Dummy cycles expected
    input wire logic [7:0] byte_count, // Bytes to read
    output logic [7:0] rd_data, // Received byte
    output logic rd_valid, // Byte pulse
    output logic done // Transfer end pulse
);
    // ------------------------------------------------------------
    // Clock divider and sequencer
    // ------------------------------------------------------------
    // Half period 4 gives 12.5 MHz, far under the limit
    mlfr_state_type state;
    logic [3:0] div;
    logic sck_q, cs_q;
    logic [3:0] out_q, oe_n_q;
    logic [63:0] sh;
    logic [6:0] cnt;
    logic two;
    logic [7:0] bytes_left;
    logic [7:0] acc;
    logic [2:0] acc_n;
    logic [3:0] io_s1, io_s2;
    always_ff @(posedge ref_clk) begin
        io_s1 <= link.io;
        io_s2 <= io_s1;
    end
    wire tick = div == SCK_HALF - 4'h1;
    wire fall = tick && sck_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= MLFR_IDLE;
            div <= 4'h0;
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            out_q <= 4'h0;
            oe_n_q <= 4'hF;
            sh <= 64'h0;
            cnt <= 7'h0;
            two <= 1'b0;
            bytes_left <= 8'h0;
            acc <= 8'h0;
            acc_n <= 3'h0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            div <= (state == MLFR_IDLE || tick) ? 4'h0 : div + 4'h1;
            if (state != MLFR_IDLE && tick) begin
                sck_q <= ~sck_q;
            end
            case (state)
                MLFR_IDLE: if (start) begin
                    cs_q <= 1'b0;
                    two <= opcode == OP_TWO_LANE || opcode == OP_TWO_LANE_WIDE
                        || opcode == 8'h00;
                    bytes_left <= byte_count;
                    acc_n <= 3'h0;
                    // Opcode first, serial on lane 0
                    sh <= wide ? {opcode, address, mode, 16'h0}
                               : {opcode, address[23:0], mode, 24'h0};
                    state <= opcode == 8'h00 ? MLFR_ADDR : MLFR_OPCODE;
                    cnt <= wide ? 7'h20 : 7'h18;
                    oe_n_q <= 4'hE;
                    if (opcode == 8'h00) begin
                        // No opcode: first pair must stand before the first rise
                        sh <= wide ? {address[29:0], mode, 26'h0}
                                   : {address[21:0], mode, 34'h0};
                        out_q <= {2'b00, wide ? address[31:30] : address[23:22]};
                        oe_n_q <= 4'hC;
                        cnt <= wide ? 7'h1E : 7'h16;
                    end
                end
                // First bit set up before the first rise, the rest on falls
                MLFR_OPCODE: if (fall || (acc_n == 3'h0 && !sck_q)) begin
                    out_q <= {3'b000, sh[63]};
                    sh <= {sh[62:0], 1'b0};
                    if (cnt == 7'h0) begin
                        state <= MLFR_ADDR;
                    end
                    if (acc_n == 3'h7) begin
                        state <= MLFR_ADDR;
                    end
                    acc_n <= acc_n + 3'h1;
                end
                MLFR_ADDR: if (fall) begin
                    // Address one or two bits per clock
                    oe_n_q <= two ? 4'hC : 4'hE;
                    out_q <= two ? {2'b00, sh[63:62]} : {3'b000, sh[63]};
                    sh <= two ? {sh[61:0], 2'b00} : {sh[62:0], 1'b0};
                    cnt <= two ? cnt - 7'h2 : cnt - 7'h1;
                    if ((two && cnt == 7'h2) || (!two && cnt == 7'h1)) begin
                        state <= two ? MLFR_MODE : MLFR_DUMMY;
                        acc_n <= 3'h0;
                        cnt <= {3'b000, dummy};
                    end
                end
                MLFR_MODE: if (fall) begin
                    // Upper mode nibble driven, lower released
                    out_q <= {2'b00, sh[63:62]};
                    sh <= {sh[61:0], 2'b00};
                    oe_n_q <= acc_n >= 3'h2 ? 4'hF : 4'hC;
                    acc_n <= acc_n + 3'h1;
                    if (acc_n == 3'h3) begin
                        oe_n_q <= 4'hF;
                        state <= MLFR_DUMMY;
                        acc_n <= 3'h0;
                    end
                end
                MLFR_DUMMY: if (fall) begin
                    // Release at first latency fall, last bit already taken
                    oe_n_q <= 4'hF;
                    if (cnt == 7'h0) begin
                        state <= MLFR_DATA;
                    end else begin
                        cnt <= cnt - 7'h1;
                    end
                end
                MLFR_DATA: if (fall) begin
                    // Sample MSB first groups one fall late: two-stage sync on both
                    // ends outlasts a half period
                    acc <= two ? {acc[5:0], io_s2[1:0]} : {acc[3:0], io_s2};
                    acc_n <= acc_n + 3'h1;
                    if ((two && acc_n == 3'h3) || (!two && acc_n == 3'h1)) begin
                        rd_data <= two ? {acc[5:0], io_s2[1:0]} : {acc[3:0], io_s2};
                        rd_valid <= 1'b1;
                        acc_n <= 3'h0;
                        bytes_left <= bytes_left - 8'h1;
                        if (bytes_left == 8'h1) begin
                            state <= MLFR_IGNORE;
                        end
                    end
                end
                MLFR_IGNORE: if (fall) begin
                    // End read by raising chip select outside mode or dummy
                    cs_q <= 1'b1;
                    done <= 1'b1;
                    state <= MLFR_IDLE;
                end
                default: state <= MLFR_IDLE;
            endcase
        end
    end
    assign link.cs_n = cs_q;
    assign link.sck = sck_q;
    assign link.host_out = out_q;
    assign link.host_oe_n = oe_n_q;
endmodule

//--- hw/mlfr_link_if.sv
// Link between the host controller and the flash read end.
// Lines resolve as wired: a driver with low enable wins, else pulled high.
interface mlfr_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] host_out;
    logic [3:0] host_oe_n;
    logic [3:0] dev_out;
    logic [3:0] dev_oe_n;
    logic [3:0] io;
    // Wire level from enables
    genvar g;
    for (g = 0; g < 4; g++) begin : gen_io
        assign io[g] = !host_oe_n[g] ? host_out[g] : (!dev_oe_n[g] ? dev_out[g] : 1'b1);
    end
    modport host (output cs_n, output sck, output host_out, output host_oe_n, input io);
    modport dev (input cs_n, input sck, input io, output dev_out, output dev_oe_n);
endinterface

//--- hw/mlfr_pkg.sv
// Shared constants for the multi-lane flash read link.
// Assumes both ends run on ref_clk at 100 MHz and the flash end samples the link clock.
package mlfr_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_FOUR_LANE = 8'h6B;
    localparam logic [7:0] OP_FOUR_LANE_WIDE = 8'h6C;
    localparam logic [7:0] OP_TWO_LANE = 8'hBB;
    localparam logic [7:0] OP_TWO_LANE_WIDE = 8'hBC;
    // ------------------------------------------------------------
    // Fields and counts
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_CONT = 4'hA;
    localparam int QUAD_ENABLE_BIT = 1;
    localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
    localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
    localparam logic [3:0] OPCODE_BITS = 4'h8;
    localparam logic [3:0] MODE_CYCLES = 4'h4;
    localparam logic [3:0] SHORT_PULSE_EDGES = 4'h8;
    localparam logic [1:0] LC_DUMMY_0 = 2'h0;
    localparam logic [1:0] LC_DUMMY_1 = 2'h1;
    localparam logic [1:0] LC_DUMMY_2 = 2'h2;
    localparam logic [1:0] LC_DUMMY_3 = 2'h3;
    // Dummy cycles per latency code (plain defaults)
    localparam logic [3:0] DUMMY_LC0 = 4'h8;
    localparam logic [3:0] DUMMY_LC1 = 4'h4;
    localparam logic [3:0] DUMMY_LC2 = 4'h2;
    localparam logic [3:0] DUMMY_LC3 = 4'h0;
    // Host link clock divider: half period in ref_clk cycles
    localparam int LINK_MAX_HZ = 108000000;
    localparam int REF_HZ = 100000000;
    localparam logic [3:0] SCK_HALF = 4'h4;
    typedef enum logic [2:0] {
        MLFR_IDLE = 3'b000,
        MLFR_OPCODE = 3'b001,
        MLFR_ADDR = 3'b010,
        MLFR_MODE = 3'b011,
        MLFR_DUMMY = 3'b100,
        MLFR_DATA = 3'b101,
        MLFR_IGNORE = 3'b110
    } mlfr_state_type;
endpackage

//--- test/mlfr_checker.sv
// Concurrent checks on the link signals between host and flash ends.
// Assumes one ref_clk domain and the wired resolution of the link interface.
module mlfr_checker (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Sync reset, active high
    input wire logic cs_n, // Chip select, active low
    input wire logic sck, // Link clock
    input wire logic [3:0] host_out, // Host line values
    input wire logic [3:0] host_oe_n, // Host enables, low drives
    input wire logic [3:0] dev_out, // Flash line values
    input wire logic [3:0] dev_oe_n // Flash enables, low drives
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Link checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Contention would corrupt both ends at turnaround
    a_no_contention: assert property ((host_oe_n | dev_oe_n) == 4'hF)
        else $error("host and flash drive one line together");
    a_dev_cs_release: assert property (cs_n [*6] |-> dev_oe_n == 4'hF)
        else $error("flash still drives lines with chip select high");
    a_host_cs_release: assert property (cs_n && $past(cs_n) |-> host_oe_n == 4'hF)
        else $error("host drives lines outside a frame");
    a_dev_on_fall: assert property (
        dev_oe_n != 4'hF && $stable(dev_oe_n) && $changed(dev_out) |-> !sck)
        else $error("flash data changed while link clock high");
    a_host_on_fall: assert property (
        host_oe_n != 4'hF && $stable(host_oe_n) && $changed(host_out) |-> !sck)
        else $error("host bits changed while link clock high");
    // Half period of four cycles keeps the link below its top rate
    a_sck_spacing: assert property ($changed(sck) |=> $stable(sck) [*3])
        else $error("link clock half period too short");
    a_cs_fall_low: assert property ($fell(cs_n) |-> !sck)
        else $error("frame opened with link clock high");
    a_dev_lanes: assert property (dev_oe_n inside {4'hF, 4'hC, 4'h0})
        else $error("flash drives an illegal lane set");
    a_host_lanes: assert property (host_oe_n inside {4'hF, 4'hE, 4'hC})
        else $error("host drives an illegal lane set");
endmodule

//--- test/multi_lane_flash_read_bench.sv
// Bench joining host and flash ends; reads are issued through the host port.
// Assumes the flash array pattern byte i = i*7+3 over 256 bytes.
module multi_lane_flash_read_bench
    import mlfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset = 1'b1, start = 1'b0, wide = 1'b0, wsel = 1'b0;
    logic [7:0] opcode = 8'h00, mode = 8'h00, byte_count = 8'h01, cfg = 8'h00;
    logic [31:0] address = 32'h0;
    logic [3:0] dummy = 4'h0;
    logic [7:0] rd_data;
    logic rd_valid, done, continuous_mode, busy;
    int miscompares = 0, samples_checked = 0;
    mlfr_link_if link();
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    mlfr_dev u_mlfr_dev (.ref_clk(ref_clk), .reset(reset), .link(link),
        .first_config_register(cfg), .wide_address_select(wsel),
        .continuous_mode(continuous_mode), .busy(busy));
    mlfr_host u_mlfr_host (.ref_clk(ref_clk), .reset(reset), .link(link), .start(start),
        .opcode(opcode), .address(address), .wide(wide), .mode(mode), .dummy(dummy),
        .byte_count(byte_count), .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
    mlfr_checker u_mlfr_checker (.ref_clk(ref_clk), .reset(reset), .cs_n(link.cs_n),
        .sck(link.sck), .host_out(link.host_out), .host_oe_n(link.host_oe_n),
        .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n));
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Dummy count the flash takes from the latency code
    function logic [3:0] lat(input logic [1:0] lc);
        return lc == LC_DUMMY_0 ? DUMMY_LC0 : lc == LC_DUMMY_1 ? DUMMY_LC1 :
            lc == LC_DUMMY_2 ? DUMMY_LC2 : DUMMY_LC3;
    endfunction
    // One read; refused reads see only the pulled-up lines
    task run(input logic [7:0] op, input logic [31:0] a, input logic w, input logic [7:0] md,
        input logic [7:0] n, input logic refused);
        int k;
        int t;
        logic [7:0] e;
        @(posedge ref_clk);
        opcode <= op;
        address <= a;
        wide <= w;
        mode <= md;
        byte_count <= n;
        dummy <= lat(cfg[7:6]);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        k = 0;
        for (t = 0; t < 20000; t++) begin
            @(posedge ref_clk);
            #1;
            if (rd_valid === 1'b1) begin
                e = refused ? 8'hFF : 8'((a[7:0] + k) * 7 + 3);
                check("rd_data", rd_data, e);
                check("busy", {7'h0, busy}, 8'h01);
                k++;
            end
            if (done === 1'b1) break;
        end
        if (t == 20000) begin
            miscompares++;
            give_verdict();
        end
        check("byte count", 8'(k), n);
        // Chip select gap lets the flash see the frame end
        repeat (12) @(posedge ref_clk);
        check("busy", {7'h0, busy}, 8'h00);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        cfg <= {LC_DUMMY_1, 4'h0, 1'b1, 1'b0};
        run(OP_FOUR_LANE, 32'h0000_0010, 1'b0, 8'h00, 8'h03, 1'b0);
        run(OP_FOUR_LANE_WIDE, 32'h1200_00FE, 1'b1, 8'h00, 8'h04, 1'b0);
        wsel <= 1'b1;
        run(OP_FOUR_LANE, 32'h0300_0021, 1'b1, 8'h00, 8'h02, 1'b0);
        wsel <= 1'b0;
        cfg <= {LC_DUMMY_3, 4'h0, 1'b0, 1'b0};
        run(OP_FOUR_LANE, 32'h0000_0040, 1'b0, 8'h00, 8'h02, 1'b1);
        // Every latency code on the two-lane read
        for (int lc = 0; lc < 4; lc++) begin
            cfg <= {2'(lc), 4'h0, 1'b1, 1'b0};
            run(OP_TWO_LANE, 32'h80 + lc, 1'b0, 8'h5F, 8'h02, 1'b0);
            check("continuous", {7'h0, continuous_mode}, 8'h00);
        end
        run(OP_TWO_LANE_WIDE, 32'hAB00_00C7, 1'b1, 8'hA0, 8'h02, 1'b0);
        check("continuous", {7'h0, continuous_mode}, 8'h01);
        run(8'h00, 32'h0000_0033, 1'b1, 8'hA5, 8'h03, 1'b0);
        check("continuous", {7'h0, continuous_mode}, 8'h01);
        run(8'h00, 32'h0000_0009, 1'b1, 8'h3A, 8'h01, 1'b0);
        check("continuous", {7'h0, continuous_mode}, 8'h00);
        run(OP_TWO_LANE, 32'h0000_00F0, 1'b0, 8'h00, 8'h01, 1'b0);
        give_verdict();
    end
endmodule
